//--- src/aisr_readout.v
`timescale 1ns/1ps
`include "aisr_defs.vh"
module aisr_readout #(
    parameter HALF_CYC = `AISR_HALF_CYC,
    parameter EXT_OSC_CYC = 10,
    parameter POR_CYC = `AISR_POR_CYC,
    parameter CONV_CYC = `AISR_CONV_CYC,
    parameter RES_W = 24
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire sdi_i,
    input wire sck_i,
    input wire conversion_clock_select_i,
    input wire [RES_W-1:0] result_i,
    input wire result_valid_i,
    output reg result_ready_o,
    output reg sck_o,
    output reg sck_oe_o,
    output reg sck_pullup_o,
    output reg sdo_o,
    output reg sdo_oe_o,
    output reg [`AISR_ADDR_W-1:0] channel_o,
    output reg conv_start_o,
    output reg ext_clk_mode_o,
    output reg continuous_o
);
    localparam ST_CONV = 3'd0;
    localparam ST_SLEEP = 3'd1;
    localparam ST_TEST = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_HOLD = 3'd4;
    localparam [15:0] TEST_INT = `AISR_TEST_CYC;
    localparam [15:0] TEST_EXT =
        (`AISR_EXT_TENTHS * EXT_OSC_CYC + 9) / 10;
    localparam [15:0] HALF = HALF_CYC;
    localparam [31:0] POR = POR_CYC;
    localparam [15:0] CONV = CONV_CYC;

    reg [1:0] cs_sync;
    reg [1:0] sdi_sync;
    reg [1:0] sck_sync;
    reg [1:0] fsel_sync;
    reg cs_q;
    reg [31:0] por_cnt;
    reg por_done;
    reg [2:0] state;
    reg [15:0] timer;
    reg [5:0] bit_cnt;
    reg [31:0] shreg;
    reg [`AISR_ADDR_W-1:0] addr_sh;
    reg fsel_ext;
    reg fsel_q;
    // keeps the pull-up on after a status test ended by select going high, until the pin is back high
    reg pu_hold;
    wire cs_n;
    wire sck_pin;
    wire cs_fall;
    wire cs_rise;
    wire [RES_W-1:0] buf_data;
    wire buf_valid;
    wire buf_ready;
    wire buf_in_ready;

    assign cs_n = cs_sync[1];
    assign sck_pin = sck_sync[1];
    assign cs_fall = cs_q && !cs_n;
    assign cs_rise = !cs_q && cs_n;
    assign buf_ready = (state == ST_CONV) && (timer == 16'h0000) && por_done;

    function [15:0] test_delay;
        input ext;
        begin
            test_delay = ext ? TEST_EXT : TEST_INT;
        end
    endfunction

    aisr_buf2 #(
        .WIDTH(RES_W)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(result_i),
        .in_valid_i(result_valid_i && result_ready_o),
        .in_ready_o(buf_in_ready),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready)
    );

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            cs_sync <= 2'b11;
            sdi_sync <= 2'b00;
            sck_sync <= 2'b11;
            fsel_sync <= 2'b00;
            cs_q <= 1'b1;
            fsel_q <= 1'b0;
            fsel_ext <= 1'b0;
        end
        else
        begin
            cs_sync <= {cs_sync[0], cs_n_i};
            sdi_sync <= {sdi_sync[0], sdi_i};
            sck_sync <= {sck_sync[0], sck_i};
            fsel_sync <= {fsel_sync[0], conversion_clock_select_i};
            cs_q <= cs_n;
            fsel_q <= fsel_sync[1];
            // toggling select pin means an external oscillator drives it
            if (fsel_q != fsel_sync[1])
                fsel_ext <= 1'b1;
        end
    end

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            por_cnt <= 32'h0000_0000;
            por_done <= 1'b0;
            state <= ST_CONV;
            timer <= 16'h0000;
            bit_cnt <= 6'd0;
            shreg <= 32'h0000_0000;
            addr_sh <= `AISR_ADDR_RST;
            channel_o <= `AISR_ADDR_RST;
            result_ready_o <= 1'b0;
            pu_hold <= 1'b0;
            sck_o <= 1'b1;
            sck_oe_o <= 1'b0;
            sck_pullup_o <= 1'b1;
            sdo_o <= 1'b1;
            sdo_oe_o <= 1'b0;
            conv_start_o <= 1'b0;
            ext_clk_mode_o <= 1'b0;
            continuous_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= 1'b0;
            // ready looks one word ahead so a word offered is never lost
            result_ready_o <= !((!buf_in_ready && !(buf_ready && buf_valid))
                || (buf_in_ready && buf_valid && result_valid_i
                && result_ready_o && !(buf_ready && buf_valid)));
            if (!por_done)
            begin
                por_cnt <= por_cnt + 32'h0000_0001;
                if (por_cnt == POR - 32'h0000_0001)
                begin
                    por_done <= 1'b1;
                    // select held low with the clock pin high at the end marks the 3-wire use
                    continuous_o <= sck_pin && !cs_n;
                    ext_clk_mode_o <= !sck_pin;
                    conv_start_o <= 1'b1;
                    timer <= CONV;
                end
            end
            else
            begin
                if (cs_fall && !continuous_o)
                    ext_clk_mode_o <= !sck_pin;
                if (timer != 16'h0000)
                    timer <= timer - 16'h0001;
                // pull-up follows pin level while not driven, except while pu_hold holds it on
                if (sck_pin)
                    pu_hold <= 1'b0;
                sck_pullup_o <= (sck_pin || pu_hold) && !(sck_oe_o && !sck_o);
                if (continuous_o)
                    sdo_oe_o <= 1'b1;
                else
                    sdo_oe_o <= !cs_n;
                case (state)
                    ST_CONV:
                    begin
                        sdo_o <= 1'b1;
                        sck_o <= 1'b1;
                        sck_oe_o <= continuous_o;
                        if (buf_ready && buf_valid)
                        begin
                            // done flag goes out first, as bit 31
                            shreg <= {1'b0, 1'b0,
                                      buf_data, 6'h00};
                            state <= ST_SLEEP;
                            sdo_o <= 1'b0;
                            sck_o <= 1'b0;
                            timer <= HALF;
                        end
                    end
                    ST_SLEEP:
                    begin
                        sdo_o <= 1'b0;
                        if (continuous_o)
                        begin
                            if (timer == 16'h0000)
                            begin
                                state <= ST_DATA;
                                bit_cnt <= 6'd0;
                                timer <= HALF;
                            end
                        end
                        else if (!cs_n && !ext_clk_mode_o && sck_pin)
                        begin
                            // wake for the status test
                            state <= ST_TEST;
                            sck_o <= 1'b0;
                            sck_oe_o <= 1'b1;
                            // low run to the first rise equals the delay
                            timer <= test_delay(fsel_ext) - HALF - 16'd2;
                        end
                    end
                    ST_TEST:
                    begin
                        if (cs_n)
                        begin
                            state <= ST_SLEEP;
                            sck_oe_o <= 1'b0;
                            pu_hold <= 1'b1;
                        end
                        else if (timer == 16'h0000)
                        begin
                            state <= ST_DATA;
                            bit_cnt <= 6'd0;
                            timer <= HALF;
                        end
                    end
                    ST_DATA:
                    begin
                        if (cs_rise && !continuous_o)
                        begin
                            // abort: partial address dropped
                            if (!sck_o)
                                sck_oe_o <= 1'b0; // line left low
                            else
                                sck_oe_o <= 1'b0;
                            sdo_o <= 1'b1;
                            state <= ST_CONV;
                            conv_start_o <= 1'b1;
                            timer <= CONV;
                        end
                        else if (timer == 16'h0000)
                        begin
                            timer <= HALF;
                            sck_o <= !sck_o;
                            if (!sck_o)
                            begin
                                // rising edge: sample address
                                addr_sh <= {addr_sh[`AISR_ADDR_W-2:0],
                                            sdi_sync[1]};
                                bit_cnt <= bit_cnt + 6'd1;
                                if (bit_cnt == 6'd4)
                                    channel_o <= {addr_sh[`AISR_ADDR_W-2:0],
                                                  sdi_sync[1]};
                                if (bit_cnt == 6'd31)
                                    state <= ST_HOLD;
                            end
                            else
                            begin
                                // falling edge: next result bit
                                sdo_o <= shreg[31];
                                shreg <= {shreg[30:0], 1'b0};
                            end
                        end
                    end
                    ST_HOLD:
                    begin
                        if (timer == 16'h0000)
                        begin
                            sdo_o <= 1'b1;
                            sck_o <= 1'b1;
                            sck_oe_o <= continuous_o;
                            state <= ST_CONV;
                            conv_start_o <= 1'b1;
                            timer <= CONV;
                        end
                    end
                    default:
                    begin
                        state <= ST_CONV;
                    end
                endcase
            end
        end
    end
endmodule // aisr_readout

//--- src/aisr_defs.vh
`ifndef AISR_DEFS_VH
`define AISR_DEFS_VH

// core clock rate in kHz
`define AISR_CLK_KHZ 10000
// status test delay, internal oscillator, in us
`define AISR_TEST_US 23
// cycles for a least time: round up
`define AISR_TEST_CYC ((`AISR_TEST_US * `AISR_CLK_KHZ + 999) / 1000)
// external oscillator: delay is 3.6 oscillator periods, in tenths
`define AISR_EXT_TENTHS 36
// half period of generated serial clock in core cycles, less one (each phase lasts this plus 1)
`define AISR_HALF_CYC 8
// power-on reset length in us
`define AISR_POR_US 1000
`define AISR_POR_CYC (`AISR_POR_US * `AISR_CLK_KHZ / 1000)
// bits per data cycle
`define AISR_FRAME_BITS 32
// conversion length in core cycles (plain default)
`define AISR_CONV_CYC 200
// address field width and reset value
`define AISR_ADDR_W 5
`define AISR_ADDR_RST 5'h00

`endif

//--- src/aisr_buf2.v
`timescale 1ns/1ps
// two-entry skid buffer for conversion results
module aisr_buf2 #(
    parameter WIDTH = 24
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem0;
    reg [WIDTH-1:0] mem1;
    reg [1:0] count;
    wire push;
    wire pop;

    assign push = in_valid_i && (count != 2'd2);
    assign pop = out_ready_i && (count != 2'd0);
    assign in_ready_o = (count != 2'd2);
    assign out_valid_o = (count != 2'd0);
    assign out_data_o = mem0;

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            count <= 2'd0;
            mem0 <= {WIDTH{1'b0}};
            mem1 <= {WIDTH{1'b0}};
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (count == 2'd0)
                        mem0 <= in_data_i;
                    else
                        mem1 <= in_data_i;
                    count <= count + 2'd1;
                end
                2'b01:
                begin
                    mem0 <= mem1;
                    count <= count - 2'd1;
                end
                2'b11:
                begin
                    if (count == 2'd1)
                        mem0 <= in_data_i;
                    else
                    begin
                        mem0 <= mem1;
                        mem1 <= in_data_i;
                    end
                end
                default:
                begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // aisr_buf2

//--- testbench/aisr_readout_asserts.sv
`timescale 1ns/1ps
module aisr_readout_chk #(
    parameter HALF_CYC = 8
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire sck_o,
    input wire sck_oe_o,
    input wire sck_pullup_o,
    input wire sdo_o,
    input wire sdo_oe_o,
    input wire [4:0] channel_o,
    input wire conv_start_o,
    input wire continuous_o
);
    localparam int TEST = 230;
    reg [8:0] low_run;
    reg [5:0] rises;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // abort clears the count through the conversion pulse, not through cs
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i || !sck_oe_o || sck_o)
            low_run <= 9'h000;
        else
            low_run <= low_run + 9'h001;
        if (!rst_n_i || conv_start_o)
            rises <= 6'h00;
        else if (sck_oe_o && $rose(sck_o))
            rises <= rises + 6'h01;
    end
    sdo_hiz_a: assert property (!continuous_o && cs_n_i [*4] |-> !sdo_oe_o)
        else $error("data out driven while select high");
    pullup_off_a: assert property ((sck_oe_o && !sck_o) [*2] |-> !sck_pullup_o)
        else $error("pull-up on while clock low");
    conv_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    high_half_a: assert property ($rose(sck_o) && sck_oe_o |-> sck_o [*8])
        else $error("clock high phase too short");
    low_gap_a: assert property ($rose(sck_o) && sck_oe_o |-> low_run == HALF_CYC + 1 || low_run == 2 * HALF_CYC + 2 || low_run >= TEST)
        else $error("clock low phase wrong length");
    frame_end_a: assert property (conv_start_o && rises == 6'd32 |-> sdo_o && sck_o)
        else $error("frame end without busy levels");
    rise_bound_a: assert property (rises <= 6'd32)
        else $error("more than 32 rises in a frame");
    chan_late_a: assert property ($changed(channel_o) |-> rises == 6'd4 && $rose(sck_o))
        else $error("channel changed before address complete");
    abort_conv_a: assert property ($rose(cs_n_i) && rises != 6'd0 && !continuous_o |-> ##[1:8] conv_start_o)
        else $error("abort did not start a conversion");
endmodule // aisr_readout_chk
bind aisr_readout aisr_readout_chk #(.HALF_CYC(HALF_CYC)) chk_u (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sck_o(sck_o),
    .sck_oe_o(sck_oe_o),
    .sck_pullup_o(sck_pullup_o),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .channel_o(channel_o),
    .conv_start_o(conv_start_o),
    .continuous_o(continuous_o)
);

//--- testbench/aisr_host.sv
`timescale 1ns/1ps
module aisr_host (
    input wire clk_i,
    input wire sck_drv_i,
    input wire sck_oe_i,
    input wire pullup_i,
    input wire sdo_i,
    input wire clr_i,
    input wire [4:0] addr_i,
    output reg sck_pin_o,
    output wire sdi_o,
    output reg [31:0] word_o = 32'h0000_0000,
    output reg [5:0] rises_o = 6'h00
);
    reg held = 1'b1;
    // a released line with the pull-up off keeps its last level
    always @*
    begin
        if (sck_oe_i)
            sck_pin_o = sck_drv_i;
        else if (pullup_i)
            sck_pin_o = 1'b1;
        else
            sck_pin_o = held;
    end
    always @(posedge clk_i)
    begin
        held <= sck_pin_o;
        if (clr_i)
            rises_o <= 6'h00;
        else if (sck_pin_o && !held)
        begin
            rises_o <= rises_o + 6'h01;
            word_o <= {word_o[30:0], sdo_i};
        end
    end
    // address msb first, next bit set up just after each rise
    assign sdi_o = (rises_o < 6'h05) ? addr_i[3'h4 - rises_o[2:0]] : 1'b0;
endmodule // aisr_host

//--- testbench/aisr_readout_bench.sv
`timescale 1ns/1ps
module aisr_readout_bench;
    reg core_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg cs_n_i = 1'b0;
    reg [23:0] result_i = 24'h00_0000;
    reg result_valid_i = 1'b0;
    reg [4:0] addr = 5'h00;
    reg [4:0] last;
    reg [23:0] r[0:4];
    wire sdi, sck_pin, result_ready_o, sck_o, sck_oe_o, sck_pullup_o;
    wire sdo_o, sdo_oe_o, conv_start_o, ext_clk_mode_o, continuous_o;
    wire [4:0] channel_o;
    wire [31:0] word;
    wire [5:0] rises;
    integer err_count = 0;
    integer compares = 0;
    integer n, i, seed;
    always #50 core_clk_i = ~core_clk_i;
    aisr_readout #(.HALF_CYC(8), .POR_CYC(20), .CONV_CYC(40)) dut_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
        .sdi_i(sdi), .sck_i(sck_pin), .conversion_clock_select_i(1'b0),
        .result_i(result_i), .result_valid_i(result_valid_i),
        .result_ready_o(result_ready_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .sck_pullup_o(sck_pullup_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .channel_o(channel_o), .conv_start_o(conv_start_o),
        .ext_clk_mode_o(ext_clk_mode_o), .continuous_o(continuous_o));
    aisr_host host_u (.clk_i(core_clk_i), .sck_drv_i(sck_o),
        .sck_oe_i(sck_oe_o), .pullup_i(sck_pullup_o), .sdo_i(sdo_o),
        .clr_i(conv_start_o | cs_n_i), .addr_i(addr), .sck_pin_o(sck_pin),
        .sdi_o(sdi), .word_o(word), .rises_o(rises));
    task close_out;
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input integer k);
        repeat (k) @(posedge core_clk_i);
    endtask
    task lim;
        if (n >= 3000)
        begin
            err_count = err_count + 1;
            close_out;
        end
    endtask
    task wait_rises(input [5:0] k);
        for (n = 0; rises !== k && n < 3000; n = n + 1)
            tick(1);
        lim;
    endtask
    task push(input [23:0] v);
        integer pn;
        result_i <= v;
        result_valid_i <= 1'b1;
        for (pn = 0; pn == 0 || (result_ready_o !== 1'b1 && pn < 3000);
             pn = pn + 1)
            tick(1);
        if (pn >= 3000)
        begin
            err_count = err_count + 1;
            close_out;
        end
        result_valid_i <= 1'b0;
    endtask
    task frame(input [23:0] v, input cs);
        if (cs)
            tick(40);
        addr <= $urandom;
        cs_n_i <= 1'b0;
        for (n = 0; rises === 6'h00 && n < 3000; n = n + 1)
            tick(1);
        lim;
        if (cs)
            check(n >= 230 && n <= 240, 1);
        wait_rises(32);
        check(word, {3'b000, v, 5'b00000});
        wait_rises(0);
        cs_n_i <= cs;
        tick(6);
        check(channel_o, addr);
        check(sdo_oe_o, !cs);
    endtask
    initial
    begin
        seed = $urandom(57499);
        tick(12);
        check({sck_pullup_o, sdo_oe_o, conv_start_o}, 3'b100);
        rst_n_i <= 1'b1;
        tick(30);
        check(continuous_o, 1);
        for (i = 0; i < 3; i = i + 1)
        begin
            r[0] = (i == 0) ? 24'hff_ffff : $urandom;
            push(r[0]);
            frame(r[0], 1'b0);
        end
        cs_n_i <= 1'b1;
        rst_n_i <= 1'b0;
        tick(12);
        rst_n_i <= 1'b1;
        tick(30);
        for (i = 0; i < 5; i = i + 1)
            r[i] = (i == 1) ? 24'h00_0000 : $urandom;
        push(r[0]);
        push(r[1]);
        push(r[2]);
        // the fourth word waits: both buffer entries are taken
        fork
            push(r[3]);
        join_none
        tick(8);
        check(result_ready_o, 0);
        cs_n_i <= 1'b0;
        tick(60);
        check({sck_oe_o, sck_o, rises}, 8'h80);
        cs_n_i <= 1'b1;
        tick(10);
        check({sck_pullup_o, sdo_oe_o}, 2'b10);
        frame(r[0], 1'b1);
        frame(r[1], 1'b1);
        last = addr;
        addr <= ~last;
        cs_n_i <= 1'b0;
        wait_rises(3);
        cs_n_i <= 1'b1;
        for (n = 0; conv_start_o !== 1'b1 && n < 12; n = n + 1)
            tick(1);
        check(n < 12, 1);
        tick(6);
        check(channel_o, last);
        frame(r[3], 1'b1);
        push(r[4]);
        cs_n_i <= 1'b0;
        wait_rises(2);
        for (n = 0; sck_pin !== 1'b0 && n < 3000; n = n + 1)
            tick(1);
        lim;
        cs_n_i <= 1'b1;
        tick(12);
        check(sck_pin, 0);
        cs_n_i <= 1'b0;
        tick(8);
        check(ext_clk_mode_o, 1);
        close_out;
    end
    initial
    begin
        tick(100000);
        err_count = err_count + 1;
        close_out;
    end
endmodule // aisr_readout_bench
